// ### rtl/irq_agg_pkg.sv
// constants for the general purpose interrupt aggregator
package irq_agg_pkg;
    localparam int SRC_WIDTH = 64;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    // register byte offsets
    localparam logic [7:0] ADDR_MASK_FIRST_LO = 8'h00;
    localparam logic [7:0] ADDR_MASK_FIRST_HI = 8'h04;
    localparam logic [7:0] ADDR_MASK_SECOND_LO = 8'h08;
    localparam logic [7:0] ADDR_MASK_SECOND_HI = 8'h0C;
    localparam logic [7:0] ADDR_STATUS_LO = 8'h10;
    localparam logic [7:0] ADDR_STATUS_HI = 8'h14;
    localparam logic [7:0] ADDR_CLEAR = 8'h18;
    localparam logic [7:0] ADDR_MASK_STAGE_LO = 8'h1C;
    localparam logic [7:0] ADDR_MASK_STAGE_HI = 8'h20;
    localparam logic [7:0] ADDR_MASK_APPLY = 8'h24;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h28;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h2C;
    // apply register select field and clear register bit
    localparam int SEL_FIRST_BIT = 0;
    localparam int SEL_SECOND_BIT = 1;
    localparam int CLEAR_BIT = 0;
    // block event bits
    localparam int EVT_WIDTH = 2;
    localparam int EVT_FIRST_BIT = 0;
    localparam int EVT_SECOND_BIT = 1;
    // masks reset to all sources blocked
    localparam logic [63:0] MASK_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        MASK_SEL_FIRST = 2'h1,
        MASK_SEL_SECOND = 2'h2,
        MASK_SEL_BOTH = 2'h3
    } mask_sel_type;
endpackage

// ### rtl/general_purpose_irq_aggregator.sv
// interrupt aggregator: two masked pins, sticky status, axi4-lite regs
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module general_purpose_irq_aggregator #(
    parameter int NUM_SOURCES = irq_agg_pkg::SRC_WIDTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [irq_agg_pkg::SRC_WIDTH-1:0] source_active,
    output logic irq_pin_first,
    output logic irq_pin_second,
    output logic block_irq,
    input wire logic [irq_agg_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [irq_agg_pkg::DATA_WIDTH-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [irq_agg_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [irq_agg_pkg::DATA_WIDTH-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import irq_agg_pkg::*;

    logic [SRC_WIDTH-1:0] first_pin_mask_word_q;
    logic [SRC_WIDTH-1:0] second_pin_mask_word_q;
    logic [SRC_WIDTH-1:0] mask_stage_q;
    logic [SRC_WIDTH-1:0] irq_status_word_q;
    logic [SRC_WIDTH-1:0] src_q;
    logic [EVT_WIDTH-1:0] evt_status_q;
    logic [EVT_WIDTH-1:0] evt_mask_q;
    logic first_prev_q;
    logic second_prev_q;
    logic [ADDR_WIDTH-1:0] awaddr_q;
    logic aw_held_q;
    logic [DATA_WIDTH-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held_q;
    logic wr_fire;
    logic rd_fire;
    logic [SRC_WIDTH-1:0] src_used;
    logic [SRC_WIDTH-1:0] wmask64;
    logic [DATA_WIDTH-1:0] wmask32;
    logic [SRC_WIDTH-1:0] clear_bits;
    logic [DATA_WIDTH-1:0] rdata_d;
    logic rd_ok;
    logic wr_ok;
    logic first_d;
    logic second_d;

    ////////////////////////////////////////////////////////////////////////
    // source sampling; sources at or above NUM_SOURCES read as inactive
    genvar gi;
    generate
        for (gi = 0; gi < SRC_WIDTH; gi++) begin : g_src
            if (gi < NUM_SOURCES) begin : g_used
                assign src_used[gi] = source_active[gi];
            end else begin : g_unused
                assign src_used[gi] = 1'b0;
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_strb
            assign wmask32[gi*8 +: 8] = {8{wstrb_q[gi]}};
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            src_q <= '0;
        end else begin
            src_q <= src_used;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data taken in either order
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_q && !s_axi_bvalid;
        end
    end

    always_comb begin
        unique case (awaddr_q)
            ADDR_MASK_FIRST_LO, ADDR_MASK_FIRST_HI,
            ADDR_MASK_SECOND_LO, ADDR_MASK_SECOND_HI,
            ADDR_CLEAR, ADDR_MASK_STAGE_LO, ADDR_MASK_STAGE_HI,
            ADDR_MASK_APPLY, ADDR_EVT_MASK: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mask words: direct per-pin writes, or staged word applied by select
    always_comb begin
        wmask64 = '0;
        if (awaddr_q == ADDR_MASK_FIRST_HI || awaddr_q == ADDR_MASK_SECOND_HI
            || awaddr_q == ADDR_MASK_STAGE_HI) begin
            wmask64[SRC_WIDTH-1:DATA_WIDTH] = wmask32;
        end else begin
            wmask64[DATA_WIDTH-1:0] = wmask32;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mask_stage_q <= MASK_RESET;
        end else if (wr_fire && (awaddr_q == ADDR_MASK_STAGE_LO
                     || awaddr_q == ADDR_MASK_STAGE_HI)) begin
            mask_stage_q <= (mask_stage_q & ~wmask64)
                | ({wdata_q, wdata_q} & wmask64);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            first_pin_mask_word_q <= MASK_RESET;
        end else if (wr_fire && (awaddr_q == ADDR_MASK_FIRST_LO
                     || awaddr_q == ADDR_MASK_FIRST_HI)) begin
            first_pin_mask_word_q <= (first_pin_mask_word_q & ~wmask64)
                | ({wdata_q, wdata_q} & wmask64);
        end else if (wr_fire && awaddr_q == ADDR_MASK_APPLY
                     && wdata_q[SEL_FIRST_BIT]) begin
            first_pin_mask_word_q <= mask_stage_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            second_pin_mask_word_q <= MASK_RESET;
        end else if (wr_fire && (awaddr_q == ADDR_MASK_SECOND_LO
                     || awaddr_q == ADDR_MASK_SECOND_HI)) begin
            second_pin_mask_word_q <= (second_pin_mask_word_q & ~wmask64)
                | ({wdata_q, wdata_q} & wmask64);
        end else if (wr_fire && awaddr_q == ADDR_MASK_APPLY
                     && wdata_q[SEL_SECOND_BIT]) begin
            second_pin_mask_word_q <= mask_stage_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status; an active source sets over a clear in the same cycle
    always_comb begin
        clear_bits = '0;
        if (wr_fire && awaddr_q == ADDR_CLEAR && wdata_q[CLEAR_BIT]) begin
            clear_bits = irq_status_word_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_status_word_q <= '0;
        end else begin
            irq_status_word_q <= (irq_status_word_q & ~clear_bits)
                | src_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins: level, not sticky
    assign first_d = |(src_q & ~first_pin_mask_word_q);
    assign second_d = |(src_q & ~second_pin_mask_word_q);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_pin_first <= 1'b0;
            irq_pin_second <= 1'b0;
            first_prev_q <= 1'b0;
            second_prev_q <= 1'b0;
        end else begin
            irq_pin_first <= first_d;
            irq_pin_second <= second_d;
            first_prev_q <= irq_pin_first;
            second_prev_q <= irq_pin_second;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // block events: pin rising edges, cleared by reading the event status
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            evt_status_q <= '0;
        end else begin
            if (rd_fire && s_axi_araddr == ADDR_EVT_STATUS) begin
                evt_status_q <= '0;
            end
            if (irq_pin_first && !first_prev_q) begin
                evt_status_q[EVT_FIRST_BIT] <= 1'b1;
            end
            if (irq_pin_second && !second_prev_q) begin
                evt_status_q[EVT_SECOND_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            evt_mask_q <= '0;
        end else if (wr_fire && awaddr_q == ADDR_EVT_MASK) begin
            evt_mask_q <= wdata_q[EVT_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            block_irq <= 1'b0;
        end else begin
            block_irq <= |(evt_status_q & ~evt_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    always_comb begin
        rdata_d = '0;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            ADDR_MASK_FIRST_LO: rdata_d = first_pin_mask_word_q[31:0];
            ADDR_MASK_FIRST_HI: rdata_d = first_pin_mask_word_q[63:32];
            ADDR_MASK_SECOND_LO: rdata_d = second_pin_mask_word_q[31:0];
            ADDR_MASK_SECOND_HI: rdata_d = second_pin_mask_word_q[63:32];
            ADDR_STATUS_LO: rdata_d = irq_status_word_q[31:0];
            ADDR_STATUS_HI: rdata_d = irq_status_word_q[63:32];
            ADDR_MASK_STAGE_LO: rdata_d = mask_stage_q[31:0];
            ADDR_MASK_STAGE_HI: rdata_d = mask_stage_q[63:32];
            ADDR_CLEAR, ADDR_MASK_APPLY: rdata_d = '0;
            ADDR_EVT_STATUS: begin
                rdata_d = {{(DATA_WIDTH-EVT_WIDTH){1'b0}}, evt_status_q};
            end
            ADDR_EVT_MASK: begin
                rdata_d = {{(DATA_WIDTH-EVT_WIDTH){1'b0}}, evt_mask_q};
            end
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// ### bench/irq_agg_props.sv
// port checker for the interrupt aggregator
`timescale 1ns/10ps
module irq_agg_props
    import irq_agg_pkg::*;
#(
    parameter int NUM_SOURCES = SRC_WIDTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [irq_agg_pkg::SRC_WIDTH-1:0] source_active,
    input wire logic irq_pin_first,
    input wire logic irq_pin_second,
    input wire logic block_irq,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [irq_agg_pkg::DATA_WIDTH-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    logic [63:0] live;
    assign live = source_active & ((64'h1 << NUM_SOURCES) - 64'h1);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_pin_cause;
        irq_pin_first || irq_pin_second |-> $past(live, 2) != 64'h0;
    endproperty
    a_pin_cause: assert property (p_pin_cause)
        else $error("pin high with no source two cycles back");
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read data late");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data not held");
    property p_rd_drop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rd_drop: assert property (p_rd_drop)
        else $error("rvalid stuck after handshake");
    property p_ar_busy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_busy: assert property (p_ar_busy)
        else $error("arready high while read pending");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response not held");
    property p_b_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop)
        else $error("bvalid stuck after handshake");
    property p_b_resp;
        s_axi_bvalid |->
            s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR;
    endproperty
    a_b_resp: assert property (p_b_resp)
        else $error("illegal write response code");
    c_pin: cover property ($rose(irq_pin_first));
    c_blk: cover property ($rose(block_irq));
    c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind general_purpose_irq_aggregator irq_agg_props
    #(.NUM_SOURCES(NUM_SOURCES)) props (.*);

// ### bench/bb_host_model.sv
// baseband host model: axi4-lite master and interrupt service steps
`timescale 1ns/10ps
module bb_host_model (
    input wire logic clk,
    output logic [7:0] s_axi_awaddr,
    output logic [2:0] s_axi_awprot,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic [2:0] s_axi_arprot,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    import irq_agg_pkg::*;
    logic [1:0] r;
    initial begin
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid} = '0;
        {s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end while (s_axi_arvalid || s_axi_rready);
    endtask
    task automatic set_mask(input logic [1:0] sel, input logic [31:0] lo);
        wr(ADDR_MASK_STAGE_LO, lo, r);
        wr(ADDR_MASK_STAGE_HI, 32'hFFFF_FFFF, r);
        wr(ADDR_MASK_APPLY, {30'h0, sel}, r);
    endtask
    // both pins programmed before monitoring starts
    task automatic init();
        set_mask(2'h1, 32'hFFFF_FFFE);
        set_mask(2'h2, 32'hFFFF_FFFD);
    endtask
    // block the pin, fetch status, put the old mask back
    task automatic service(input logic [31:0] orig, output logic [31:0] st);
        set_mask(2'h1, 32'hFFFF_FFFF);
        rd(ADDR_STATUS_LO, st, r);
        set_mask(2'h1, orig);
    endtask
endmodule

// ### bench/testbench.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/10ps
module testbench;
    import irq_agg_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [63:0] source_active = 64'h0;
    logic irq_pin_first, irq_pin_second, block_irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int err_count = 0;
    int checks_done = 0;
    always #2.5 clk = ~clk;
    general_purpose_irq_aggregator #(.NUM_SOURCES(64)) DUT (.*);
    bb_host_model host (.*);
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic src(input logic [63:0] v, input int n);
        @(posedge clk);
        source_active <= v;
        repeat (n) @(posedge clk);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_init();
        host.rd(ADDR_MASK_FIRST_LO, d, r);
        chk("mask1 reset", 32'hFFFF_FFFF, d);
        host.init();
        host.rd(ADDR_MASK_FIRST_LO, d, r);
        chk("mask1", 32'hFFFF_FFFE, d);
        host.rd(ADDR_MASK_SECOND_LO, d, r);
        chk("mask2", 32'hFFFF_FFFD, d);
    endtask
    task automatic t_pins();
        src(64'h1, 3);
        chk("pin1 on", 32'h1, {31'h0, irq_pin_first});
        chk("pin2 off", 32'h0, {31'h0, irq_pin_second});
        src(64'h3, 3);
        chk("pin2 on", 32'h1, {31'h0, irq_pin_second});
        src(64'h0, 3);
        chk("pin1 gone", 32'h0, {31'h0, irq_pin_first});
        host.rd(ADDR_STATUS_LO, d, r);
        chk("status kept", 32'h3, d);
    endtask
    task automatic t_clear();
        src(64'h0000_0100_0000_0000, 3);
        chk("masked pin", 32'h0, {31'h0, irq_pin_first});
        host.wr(ADDR_CLEAR, 32'h1, r);
        host.rd(ADDR_STATUS_HI, d, r);
        chk("fault stays", 32'h0000_0100, d);
        src(64'h0, 2);
        host.wr(ADDR_CLEAR, 32'h1, r);
        host.rd(ADDR_STATUS_HI, d, r);
        chk("clear hi", 32'h0, d);
        host.rd(ADDR_STATUS_LO, d, r);
        chk("clear lo", 32'h0, d);
    endtask
    task automatic t_evt();
        chk("blk on", 32'h1, {31'h0, block_irq});
        host.rd(ADDR_EVT_STATUS, d, r);
        chk("evt both", 32'h3, d);
        src(64'h0, 3);
        chk("blk off", 32'h0, {31'h0, block_irq});
        host.wr(ADDR_EVT_MASK, 32'h3, r);
        src(64'h1, 6);
        chk("blk masked", 32'h0, {31'h0, block_irq});
        host.rd(ADDR_EVT_STATUS, d, r);
        chk("evt first", 32'h1, d);
        host.wr(ADDR_EVT_MASK, 32'h0, r);
    endtask
    task automatic t_service();
        chk("pin1 rise", 32'h1, {31'h0, irq_pin_first});
        host.service(32'hFFFF_FFFE, d);
        chk("svc status", 32'h1, d);
        src(64'h1, 3);
        chk("pin1 back", 32'h1, {31'h0, irq_pin_first});
        src(64'h0, 2);
    endtask
    // one apply touching both pins, then a direct per-pin mask write
    task automatic t_both();
        host.set_mask(2'h3, 32'hFFFF_FFFF);
        src(64'h3, 3);
        chk("both masked 1", 32'h0, {31'h0, irq_pin_first});
        chk("both masked 2", 32'h0, {31'h0, irq_pin_second});
        host.rd(ADDR_MASK_FIRST_LO, d, r);
        chk("mask1 both", 32'hFFFF_FFFF, d);
        host.rd(ADDR_MASK_SECOND_LO, d, r);
        chk("mask2 both", 32'hFFFF_FFFF, d);
        host.wr(ADDR_MASK_FIRST_LO, 32'hFFFF_FFFD, r);
        chk("direct wr resp", {30'h0, RESP_OKAY}, {30'h0, r});
        repeat (3) @(posedge clk);
        chk("direct mask 1", 32'h1, {31'h0, irq_pin_first});
        chk("direct mask 2", 32'h0, {31'h0, irq_pin_second});
        src(64'h0, 2);
    endtask
    task automatic t_err();
        host.rd(8'h3C, d, r);
        chk("bad rd resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("bad rd data", 32'h0, d);
        host.wr(ADDR_STATUS_LO, 32'hFFFF_FFFF, r);
        chk("ro wr resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_init();
        t_pins();
        t_clear();
        t_evt();
        t_service();
        t_both();
        t_err();
        results();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        results();
    end
endmodule
